//--- core/pmi_pkg.sv
// constants and types shared by the mac-facing pin interface
// How it works
// - transmit data captured on the matching transmit clock
// - mii error sends invalid, then halt symbols
// - gmii error emits invalid code-groups in frame
// - receive clock per speed: 2.5, 25, 125; gigabit gives 50 here, the fastest the system clock can make
// - receive data driven synchronous to receive clock
// - data valid high while receive data present
// - rgmii transmit control carries enable and error
// - rgmii receive control carries valid and error
// - receive error flagged on receive clock; rgmii unused
// - half duplex collision on simultaneous tx/rx
// - collision low in full duplex and rgmii
// - half duplex carrier sense on tx or rx; carrier sense low in rgmii
// - full duplex carrier sense only on receive; held low at gigabit
// - mii transmit clock 2.5 or 25 mhz
package pmi_pkg;
	localparam int CLK_HZ   = 100_000_000;
	localparam int F10_HZ   = 2_500_000;
	localparam int F100_HZ  = 25_000_000;
	localparam int F1000_HZ = 125_000_000;
	localparam int DIV_W    = 8;

	// half period in system cycles, rounded down, never below one
	function automatic int half_cnt(input int f);
		int h;
		h = CLK_HZ / (2 * f);
		return (h < 1) ? 1 : h;
	endfunction

	localparam logic [DIV_W-1:0] HALF_10   = DIV_W'(half_cnt(F10_HZ));
	localparam logic [DIV_W-1:0] HALF_100  = DIV_W'(half_cnt(F100_HZ));
	localparam logic [DIV_W-1:0] HALF_1000 = DIV_W'(half_cnt(F1000_HZ));

	// bit positions in the synchronised transmit pin vector
	localparam int PIN_W  = 11;
	localparam int PB_CLK = 10;
	localparam int PB_ER  = 9;
	localparam int PB_EN  = 8;

	typedef enum logic [1:0] {
		PMI_MII   = 2'h0,
		PMI_GMII  = 2'h1,
		PMI_RGMII = 2'h2
	} pmi_mode_e;

	typedef enum logic [1:0] {
		PMI_S10   = 2'h0,
		PMI_S100  = 2'h1,
		PMI_S1000 = 2'h2
	} pmi_speed_e;

	typedef enum logic [1:0] {
		PMI_K_DATA  = 2'h0,
		PMI_K_INVAL = 2'h1,
		PMI_K_HALT  = 2'h2,
		PMI_K_END   = 2'h3
	} pmi_kind_e;
endpackage

//--- core/pmi_clk_if.sv
// divider control and generated clock level with edge strobes
`timescale 1ns/1ps
interface pmi_clk_if;
	logic                      run;
	logic [pmi_pkg::DIV_W-1:0] half;
	logic                      lvl;
	logic                      rise;
	logic                      fall;
	modport gen (input run, input half, output lvl, output rise, output fall);
	modport snk (output run, output half, input lvl, input rise, input fall);
endinterface

//--- core/pmi_clkgen.sv
// divider that makes an outgoing interface clock from the system clock
`timescale 1ns/1ps
module pmi_clkgen (
	// clock and reset
	input  wire logic clock,
	input  wire logic nrst,
	// divider control and generated clock
	pmi_clk_if.gen    ck
);
	logic [pmi_pkg::DIV_W-1:0] cnt_r;
	logic [pmi_pkg::DIV_W-1:0] cnt_nxt;
	logic                      lvl_r;
	logic                      lvl_nxt;
	logic                      flip;

	// >= lets a speed change shorten the current half period at once
	always_comb begin
		flip    = ck.run && (cnt_r >= ck.half - 1'b1);
		cnt_nxt = (flip || !ck.run) ? '0 : cnt_r + 1'b1;
		lvl_nxt = ck.run ? (lvl_r ^ flip) : 1'b0;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
			lvl_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	assign ck.lvl  = lvl_r;
	assign ck.rise = flip && !lvl_r;
	assign ck.fall = lvl_r && (flip || !ck.run);
endmodule

//--- core/pmi_top.sv
// mac-facing mii, gmii and rgmii pin logic of the transceiver
`timescale 1ns/1ps
module pmi_top (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       nrst,
	// configuration from the transceiver core
	input  wire logic [1:0] mode,
	input  wire logic [1:0] speed,
	input  wire logic       full_duplex,
	// transmit pins from the mac
	input  wire logic       gtx_clk,
	input  wire logic [7:0] txd,
	input  wire logic       tx_en_ctl,
	input  wire logic       tx_er,
	output logic            tx_clk,
	// receive and status pins toward the mac
	output logic            rx_clk,
	output logic [7:0]      rxd,
	output logic            rx_dv_ctl,
	output logic            rx_er,
	output logic            col,
	output logic            crs,
	// transmit symbols toward the media side
	output logic            tx_sym_valid,
	output logic [7:0]      tx_sym,
	output logic [1:0]      tx_sym_kind,
	// receive bytes from the media side
	input  wire logic       rx_sym_valid,
	input  wire logic [7:0] rx_sym,
	input  wire logic       rx_sym_err,
	output logic            rx_sym_ready,
	input  wire logic       rx_carrier
);
	typedef enum logic [3:0] {
		TX_IDLE  = 4'h1,
		TX_DATA  = 4'h2,
		TX_INVAL = 4'h4,
		TX_HALT  = 4'h8
	} pmi_tx_e;

	typedef enum logic [2:0] {
		RX_IDLE = 3'h1,
		RX_LO   = 3'h2,
		RX_HI   = 3'h4
	} pmi_rx_e;

	logic is_mii;
	logic is_gmii;
	logic is_rgmii;
	logic is_gig;

	assign is_mii   = mode == pmi_pkg::PMI_MII;
	assign is_gmii  = mode == pmi_pkg::PMI_GMII;
	assign is_rgmii = mode == pmi_pkg::PMI_RGMII;
	assign is_gig   = speed == pmi_pkg::PMI_S1000;

	// pin synchronisers; d_r is one cycle older than s2_r so data taken
	// at a detected clock edge predates that edge and never races it
	logic [pmi_pkg::PIN_W-1:0] s1_r;
	logic [pmi_pkg::PIN_W-1:0] s2_r;
	logic [pmi_pkg::PIN_W-1:0] d_r;
	logic                      g_rise;
	logic                      g_fall;

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s1_r <= '0;
			s2_r <= '0;
			d_r  <= '0;
		end else begin
			s1_r <= {gtx_clk, tx_er, tx_en_ctl, txd};
			s2_r <= s1_r;
			d_r  <= s2_r;
		end
	end

	assign g_rise = s2_r[pmi_pkg::PB_CLK] && !d_r[pmi_pkg::PB_CLK];
	assign g_fall = !s2_r[pmi_pkg::PB_CLK] && d_r[pmi_pkg::PB_CLK];

	// outgoing clocks
	pmi_clk_if txc();
	pmi_clk_if rxc();

	assign txc.run  = is_mii && !is_gig;
	assign txc.half = (speed == pmi_pkg::PMI_S10) ? pmi_pkg::HALF_10
		: pmi_pkg::HALF_100;
	assign rxc.run  = 1'b1;
	// gigabit rx clock is the fastest this system clock can make
	assign rxc.half = (speed == pmi_pkg::PMI_S10) ? pmi_pkg::HALF_10
		: (speed == pmi_pkg::PMI_S100) ? pmi_pkg::HALF_100
		: pmi_pkg::HALF_1000;

	pmi_clkgen u_txc (
		.clock (clock),
		.nrst  (nrst),
		.ck    (txc)
	);

	pmi_clkgen u_rxc (
		.clock (clock),
		.nrst  (nrst),
		.ck    (rxc)
	);

	assign tx_clk = txc.lvl;
	assign rx_clk = rxc.lvl;

	// transmit path
	pmi_tx_e    tx_state_r;
	pmi_tx_e    tx_state_nxt;
	logic [3:0] lo_r;
	logic [3:0] lo_nxt;
	logic       lo_en_r;
	logic       lo_en_nxt;
	logic       sv_r;
	logic       sv_nxt;
	logic [7:0] sym_r;
	logic [7:0] sym_nxt;
	logic [1:0] kind_r;
	logic [1:0] kind_nxt;
	logic       u_valid;
	logic [7:0] u_data;
	logic       u_en;
	logic       u_er;

	always_comb begin
		u_data    = d_r[7:0];
		u_en      = d_r[pmi_pkg::PB_EN];
		u_er      = d_r[pmi_pkg::PB_ER];
		lo_nxt    = lo_r;
		lo_en_nxt = lo_en_r;
		if (is_rgmii) begin
			if (g_rise) begin
				lo_nxt    = d_r[3:0];
				lo_en_nxt = d_r[pmi_pkg::PB_EN];
			end
			// falling edge carries enable xor error
			u_valid = g_fall;
			u_data  = {d_r[3:0], lo_r};
			u_en    = lo_en_r;
			u_er    = lo_en_r ^ d_r[pmi_pkg::PB_EN];
		end else if (is_mii) begin
			u_valid = txc.rise;
			u_data  = {4'h0, d_r[3:0]};
		end else begin
			u_valid = g_rise;
		end
		tx_state_nxt = tx_state_r;
		sv_nxt       = 1'b0;
		sym_nxt      = sym_r;
		kind_nxt     = kind_r;
		if (u_valid) begin
			sym_nxt = u_data;
			sv_nxt  = 1'b1;
			if (u_en && u_er) begin
				if (is_mii && (tx_state_r == TX_INVAL
					|| tx_state_r == TX_HALT)) begin
					kind_nxt     = pmi_pkg::PMI_K_HALT;
					tx_state_nxt = TX_HALT;
				end else begin
					kind_nxt     = pmi_pkg::PMI_K_INVAL;
					tx_state_nxt = is_mii ? TX_INVAL : TX_DATA;
				end
			end else if (u_en) begin
				kind_nxt     = pmi_pkg::PMI_K_DATA;
				tx_state_nxt = TX_DATA;
			end else begin
				// error without enable (carrier extension) is not sent
				sv_nxt       = tx_state_r != TX_IDLE;
				kind_nxt     = pmi_pkg::PMI_K_END;
				tx_state_nxt = TX_IDLE;
			end
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tx_state_r <= TX_IDLE;
			lo_r       <= 4'h0;
			lo_en_r    <= 1'b0;
			sv_r       <= 1'b0;
			sym_r      <= 8'h00;
			kind_r     <= 2'h0;
		end else begin
			tx_state_r <= tx_state_nxt;
			lo_r       <= lo_nxt;
			lo_en_r    <= lo_en_nxt;
			sv_r       <= sv_nxt;
			sym_r      <= sym_nxt;
			kind_r     <= kind_nxt;
		end
	end

	assign tx_sym_valid = sv_r;
	assign tx_sym       = sym_r;
	assign tx_sym_kind  = kind_r;

	// receive path: a single holding byte, no deeper buffer
	pmi_rx_e    rx_state_r;
	pmi_rx_e    rx_state_nxt;
	logic [7:0] hold_r;
	logic [7:0] hold_nxt;
	logic       herr_r;
	logic       herr_nxt;
	logic       hval_r;
	logic       hval_nxt;
	logic [7:0] rxd_r;
	logic [7:0] rxd_nxt;
	logic       dv_r;
	logic       dv_nxt;
	logic       er_r;
	logic       er_nxt;
	logic       consume;
	logic       accept;

	always_comb begin
		rx_state_nxt = rx_state_r;
		rxd_nxt      = rxd_r;
		dv_nxt       = dv_r;
		er_nxt       = er_r;
		consume      = 1'b0;
		accept       = rx_sym_valid && !hval_r;
		// all pin updates happen on rx clock edges
		if (rxc.fall) begin
			if (is_mii && rx_state_r == RX_LO) begin
				rxd_nxt      = {4'h0, hold_r[7:4]};
				consume      = 1'b1;
				rx_state_nxt = RX_HI;
			end else if (hval_r) begin
				rxd_nxt      = is_gmii ? hold_r : {4'h0, hold_r[3:0]};
				dv_nxt       = 1'b1;
				er_nxt       = !is_rgmii && herr_r;
				consume      = is_gmii;
				rx_state_nxt = is_gmii ? RX_HI : RX_LO;
			end else begin
				rxd_nxt      = 8'h00;
				dv_nxt       = 1'b0;
				er_nxt       = 1'b0;
				rx_state_nxt = RX_IDLE;
			end
		end else if (rxc.rise && is_rgmii && rx_state_r == RX_LO) begin
			rxd_nxt      = {4'h0, hold_r[7:4]};
			dv_nxt       = !herr_r;
			consume      = 1'b1;
			rx_state_nxt = RX_HI;
		end
		hval_nxt = (hval_r && !consume) || accept;
		hold_nxt = accept ? rx_sym : hold_r;
		herr_nxt = accept ? rx_sym_err : herr_r;
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rx_state_r <= RX_IDLE;
			hold_r     <= 8'h00;
			herr_r     <= 1'b0;
			hval_r     <= 1'b0;
			rxd_r      <= 8'h00;
			dv_r       <= 1'b0;
			er_r       <= 1'b0;
		end else begin
			rx_state_r <= rx_state_nxt;
			hold_r     <= hold_nxt;
			herr_r     <= herr_nxt;
			hval_r     <= hval_nxt;
			rxd_r      <= rxd_nxt;
			dv_r       <= dv_nxt;
			er_r       <= er_nxt;
		end
	end

	assign rxd          = rxd_r;
	assign rx_dv_ctl    = dv_r;
	assign rx_er        = er_r;
	assign rx_sym_ready = !hval_r;

	// collision and carrier sense, free of the interface clocks
	logic tx_act;
	logic col_r;
	logic col_nxt;
	logic crs_r;
	logic crs_nxt;

	assign tx_act = tx_state_r != TX_IDLE;

	always_comb begin
		col_nxt = !is_rgmii && !full_duplex && tx_act && rx_carrier;
		crs_nxt = 1'b0;
		if (!is_rgmii) begin
			crs_nxt = full_duplex ? (!is_gig && rx_carrier)
				: (tx_act || rx_carrier);
		end
	end

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			col_r <= 1'b0;
			crs_r <= 1'b0;
		end else begin
			col_r <= col_nxt;
			crs_r <= crs_nxt;
		end
	end

	assign col = col_r;
	assign crs = crs_r;

	// checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	logic rx_ev;
	assign rx_ev = rxc.rise || rxc.fall;

	property p_mii_cap;
		(is_mii && txc.rise && d_r[pmi_pkg::PB_EN] && !d_r[pmi_pkg::PB_ER])
		|=> tx_sym_valid && tx_sym == {4'h0, $past(d_r[3:0])};
	endproperty
	a_mii_cap: assert property (p_mii_cap)
		else $error("mii nibble not taken on tx clock");

	property p_mii_halt;
		(is_mii && u_valid && u_en && u_er && tx_state_r == TX_INVAL)
		|=> tx_sym_valid && tx_sym_kind == pmi_pkg::PMI_K_HALT;
	endproperty
	a_mii_halt: assert property (p_mii_halt)
		else $error("halt symbol missing after invalid");

	property p_gmii_err;
		(is_gmii && g_rise && d_r[pmi_pkg::PB_EN] && d_r[pmi_pkg::PB_ER])
		|=> tx_sym_valid && tx_sym_kind == pmi_pkg::PMI_K_INVAL;
	endproperty
	a_gmii_err: assert property (p_gmii_err)
		else $error("gmii error not sent as invalid");

	property p_rgmii_tx;
		(is_rgmii && g_fall && lo_en_r && !d_r[pmi_pkg::PB_EN])
		|=> tx_sym_kind == pmi_pkg::PMI_K_INVAL
			&& tx_sym == {$past(d_r[3:0]), $past(lo_r)};
	endproperty
	a_rgmii_tx: assert property (p_rgmii_tx)
		else $error("rgmii transmit control decode wrong");

	property p_rxclk_gig;
		(speed == pmi_pkg::PMI_S1000) [*3] |-> rx_clk != $past(rx_clk);
	endproperty
	a_rxclk_gig: assert property (p_rxclk_gig)
		else $error("gigabit rx clock not toggling");

	property p_txclk_100;
		(is_mii && speed == pmi_pkg::PMI_S100 && $rose(tx_clk))
		|-> ##2 ($fell(tx_clk) || !is_mii || speed != pmi_pkg::PMI_S100);
	endproperty
	a_txclk_100: assert property (p_txclk_100)
		else $error("mii tx clock half period wrong");

	property p_rx_sync;
		!$stable(rxd) || !$stable(rx_dv_ctl) |-> $past(rx_ev);
	endproperty
	a_rx_sync: assert property (p_rx_sync)
		else $error("rx pins changed off an rx clock edge");

	property p_gmii_dv;
		(is_gmii && rxc.fall && hval_r)
		|=> rx_dv_ctl && rxd == $past(hold_r) && rx_er == $past(herr_r);
	endproperty
	a_gmii_dv: assert property (p_gmii_dv)
		else $error("gmii receive byte not presented");

	property p_rgmii_rxctl;
		(is_rgmii && rxc.rise && rx_state_r == RX_LO)
		|=> rx_dv_ctl == !$past(herr_r) && !rx_er;
	endproperty
	a_rgmii_rxctl: assert property (p_rgmii_rxctl)
		else $error("rgmii receive control wrong");

	property p_col;
		(!is_rgmii && !full_duplex && tx_act && rx_carrier) |=> col;
	endproperty
	a_col: assert property (p_col)
		else $error("collision not raised");

	property p_col_low;
		(is_rgmii || full_duplex) |=> !col;
	endproperty
	a_col_low: assert property (p_col_low)
		else $error("collision raised in full duplex or rgmii");

	property p_crs;
		(!is_rgmii && ((!full_duplex && (tx_act || rx_carrier))
			|| (full_duplex && !is_gig && rx_carrier))) |=> crs;
	endproperty
	a_crs: assert property (p_crs)
		else $error("carrier sense missing");
endmodule

//--- sim/pmi_mac_model.sv
// behavioural mac driving the transmit pins in mii, gmii and rgmii
`timescale 1ns/1ps
module pmi_mac_model (
	// mode and phy transmit clock
	input  wire logic [1:0] mode,
	input  wire logic       tx_clk,
	// transmit pins toward the phy
	output logic            gtx_clk,
	output logic [7:0]      txd,
	output logic            tx_en_ctl,
	output logic            tx_er
);
	// offset keeps the link clock edges away from the system clock edges
	initial begin
		gtx_clk = 1'b0;
		txd = 8'h00;
		tx_en_ctl = 1'b0;
		tx_er = 1'b0;
		#3;
		forever #62.5 gtx_clk = ~gtx_clk;
	end

	// one unit; pins change just after the edge that took the previous unit.
	// idle data lines show the inverse of the last value, not a stale copy
	task automatic send(input logic [7:0] d, input logic en, input logic er);
		if (mode == pmi_pkg::PMI_RGMII) begin
			@(negedge gtx_clk);
			txd <= en ? {4'h0, d[3:0]} : ~txd;
			tx_en_ctl <= en;
			tx_er <= 1'b0;
			@(posedge gtx_clk);
			txd <= en ? {4'h0, d[7:4]} : ~txd;
			tx_en_ctl <= en ^ er;
		end else begin
			if (mode == pmi_pkg::PMI_MII)
				@(posedge tx_clk);
			else
				@(posedge gtx_clk);
			txd <= en ? d : ~txd;
			tx_en_ctl <= en;
			tx_er <= er;
		end
	endtask
endmodule

//--- sim/testbench.sv
// self-checking bench for the mac-facing pin logic
`timescale 1ns/1ps
module testbench;
	logic       clock, nrst, full_duplex, gtx_clk, tx_en_ctl, tx_er;
	logic       tx_clk, rx_clk, rx_dv_ctl, rx_er, col, crs, rx_carrier;
	logic       tx_sym_valid, rx_sym_valid, rx_sym_err, rx_sym_ready;
	logic [1:0] mode, speed, tx_sym_kind;
	logic [7:0] txd, rxd, tx_sym, rx_sym;
	logic [9:0] got_q[$];
	int         num_errors, tests_run, cyc;

	pmi_top uut (
		.clock(clock), .nrst(nrst), .mode(mode), .speed(speed),
		.full_duplex(full_duplex), .gtx_clk(gtx_clk), .txd(txd),
		.tx_en_ctl(tx_en_ctl), .tx_er(tx_er), .tx_clk(tx_clk),
		.rx_clk(rx_clk), .rxd(rxd), .rx_dv_ctl(rx_dv_ctl), .rx_er(rx_er),
		.col(col), .crs(crs), .tx_sym_valid(tx_sym_valid), .tx_sym(tx_sym),
		.tx_sym_kind(tx_sym_kind), .rx_sym_valid(rx_sym_valid),
		.rx_sym(rx_sym), .rx_sym_err(rx_sym_err),
		.rx_sym_ready(rx_sym_ready), .rx_carrier(rx_carrier)
	);
	pmi_mac_model mac (
		.mode(mode), .tx_clk(tx_clk), .gtx_clk(gtx_clk), .txd(txd),
		.tx_en_ctl(tx_en_ctl), .tx_er(tx_er)
	);

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	task automatic close_out;
		if (num_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// collects every transmit unit at the falling edge, where the registered
	// pulse has settled; the ceiling is far above the real run
	always @(negedge clock) begin
		if (tx_sym_valid === 1'b1)
			got_q.push_back({tx_sym_kind, tx_sym});
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cfg(input logic [1:0] m, input logic [1:0] s,
		input logic fd, input logic car);
		@(posedge clock);
		mode <= m;
		speed <= s;
		full_duplex <= fd;
		rx_carrier <= car;
		repeat (20) @(posedge clock);
		got_q.delete();
	endtask

	task automatic exp_tx(input logic [1:0] k, input logic [7:0] d,
		input logic [7:0] m);
		logic [9:0] g;
		int         i;
		for (i = 0; i < 400 && got_q.size() == 0; i++)
			@(posedge clock);
		g = (got_q.size() > 0) ? got_q.pop_front() : 10'bx;
		chk({6'h0, g[9:8], g[7:0] & m}, {6'h0, k, d & m});
	endtask

	// cycles between two rising edges of rx_clk (sel 0) or tx_clk (sel 1)
	task automatic period(input logic sel, output int n);
		logic p, c;
		int   i, t0;
		n = 0;
		t0 = -1;
		p = 1'b1;
		for (i = 0; i < 200 && n == 0; i++) begin
			@(posedge clock);
			#1;
			c = sel ? tx_clk : rx_clk;
			if (p === 1'b0 && c === 1'b1) begin
				if (t0 < 0)
					t0 = i;
				else
					n = i - t0;
			end
			p = c;
		end
	endtask

	task automatic wait_rx(input logic v);
		logic p;
		int   i;
		// step past the edge the caller returned on, so rx_clk has settled
		#1;
		p = rx_clk;
		for (i = 0; i < 200; i++) begin
			@(posedge clock);
			#1;
			if (p === ~v && rx_clk === v)
				break;
			p = rx_clk;
		end
	endtask

	// media offer held until the edge where ready is seen high
	task automatic rx_byte(input logic [7:0] b, input logic e);
		logic r;
		int   i;
		@(posedge clock);
		rx_sym_valid <= 1'b1;
		rx_sym <= b;
		rx_sym_err <= e;
		r = 1'b0;
		for (i = 0; i < 100 && r !== 1'b1; i++) begin
			#1;
			r = rx_sym_ready;
			@(posedge clock);
		end
		rx_sym_valid <= 1'b0;
		rx_sym <= ~b;
		rx_sym_err <= ~e;
	endtask

	task automatic cs_is(input logic [1:0] e);
		repeat (3) @(posedge clock);
		#1;
		chk({14'h0, col, crs}, {14'h0, e});
	endtask

	task automatic t_clocks;
		int f[3];
		int n, i, h;
		f = '{pmi_pkg::F10_HZ, pmi_pkg::F100_HZ, pmi_pkg::F1000_HZ};
		for (i = 0; i < 3; i++) begin
			h = pmi_pkg::CLK_HZ / (2 * f[i]);
			h = (h < 1) ? 2 : 2 * h;
			cfg(pmi_pkg::PMI_GMII, i[1:0], 1'b1, 1'b0);
			period(1'b0, n);
			chk(16'(n), 16'(h));
			if (i < 2) begin
				cfg(pmi_pkg::PMI_MII, i[1:0], 1'b1, 1'b0);
				period(1'b1, n);
				chk(16'(n), 16'(h));
			end
		end
	endtask

	task automatic t_gmii;
		cfg(pmi_pkg::PMI_GMII, pmi_pkg::PMI_S1000, 1'b1, 1'b0);
		mac.send(8'ha5, 1'b1, 1'b0);
		mac.send(8'h3c, 1'b1, 1'b1);
		mac.send(8'h5a, 1'b1, 1'b0);
		mac.send(8'h00, 1'b0, 1'b0);
		mac.send(8'h00, 1'b0, 1'b0);
		exp_tx(pmi_pkg::PMI_K_DATA, 8'ha5, 8'hff);
		exp_tx(pmi_pkg::PMI_K_INVAL, 8'h00, 8'h00);
		exp_tx(pmi_pkg::PMI_K_DATA, 8'h5a, 8'hff);
		exp_tx(pmi_pkg::PMI_K_END, 8'h00, 8'h00);
		chk({15'h0, tx_clk}, 16'h0);
	endtask

	task automatic t_mii;
		cfg(pmi_pkg::PMI_MII, pmi_pkg::PMI_S100, 1'b1, 1'b0);
		mac.send(8'h03, 1'b1, 1'b0);
		mac.send(8'h07, 1'b1, 1'b1);
		mac.send(8'h08, 1'b1, 1'b1);
		mac.send(8'h09, 1'b1, 1'b0);
		mac.send(8'h00, 1'b0, 1'b0);
		exp_tx(pmi_pkg::PMI_K_DATA, 8'h03, 8'h0f);
		exp_tx(pmi_pkg::PMI_K_INVAL, 8'h00, 8'h00);
		exp_tx(pmi_pkg::PMI_K_HALT, 8'h00, 8'h00);
		exp_tx(pmi_pkg::PMI_K_DATA, 8'h09, 8'h0f);
		exp_tx(pmi_pkg::PMI_K_END, 8'h00, 8'h00);
	endtask

	task automatic t_rgmii;
		cfg(pmi_pkg::PMI_RGMII, pmi_pkg::PMI_S1000, 1'b0, 1'b1);
		mac.send(8'hc6, 1'b1, 1'b0);
		mac.send(8'h81, 1'b1, 1'b1);
		cs_is(2'h0);
		mac.send(8'h00, 1'b0, 1'b0);
		exp_tx(pmi_pkg::PMI_K_DATA, 8'hc6, 8'hff);
		exp_tx(pmi_pkg::PMI_K_INVAL, 8'h00, 8'h00);
		exp_tx(pmi_pkg::PMI_K_END, 8'h00, 8'h00);
	endtask

	task automatic t_rx;
		cfg(pmi_pkg::PMI_GMII, pmi_pkg::PMI_S1000, 1'b1, 1'b0);
		rx_byte(8'he7, 1'b0);
		wait_rx(1'b0);
		chk({rx_er, rx_dv_ctl, 6'h0, rxd}, 16'h40e7);
		rx_byte(8'h18, 1'b1);
		wait_rx(1'b0);
		chk({rx_er, rx_dv_ctl, 6'h0, rxd}, 16'hc018);
		wait_rx(1'b0);
		chk({rx_er, rx_dv_ctl, 6'h0, rxd}, 16'h0000);
		cfg(pmi_pkg::PMI_RGMII, pmi_pkg::PMI_S1000, 1'b1, 1'b0);
		rx_byte(8'hb4, 1'b1);
		wait_rx(1'b0);
		chk({rx_er, rx_dv_ctl, 10'h0, rxd[3:0]}, 16'h4004);
		wait_rx(1'b1);
		chk({rx_er, rx_dv_ctl, 10'h0, rxd[3:0]}, 16'h000b);
		// mii: low nibble first, error held across both nibbles
		cfg(pmi_pkg::PMI_MII, pmi_pkg::PMI_S100, 1'b1, 1'b0);
		rx_byte(8'h5a, 1'b1);
		wait_rx(1'b0);
		chk({rx_er, rx_dv_ctl, 6'h0, rxd}, 16'hc00a);
		wait_rx(1'b0);
		chk({rx_er, rx_dv_ctl, 6'h0, rxd}, 16'hc005);
		wait_rx(1'b0);
		chk({rx_er, rx_dv_ctl, 6'h0, rxd}, 16'h0000);
	endtask

	task automatic t_colcrs;
		cfg(pmi_pkg::PMI_MII, pmi_pkg::PMI_S100, 1'b0, 1'b1);
		cs_is(2'h1);
		mac.send(8'h05, 1'b1, 1'b0);
		exp_tx(pmi_pkg::PMI_K_DATA, 8'h05, 8'h0f);
		cs_is(2'h3);
		@(posedge clock);
		full_duplex <= 1'b1;
		cs_is(2'h1);
		@(posedge clock);
		rx_carrier <= 1'b0;
		cs_is(2'h0);
		@(posedge clock);
		full_duplex <= 1'b0;
		cs_is(2'h1);
		mac.send(8'h00, 1'b0, 1'b0);
		repeat (40) @(posedge clock);
	endtask

	initial begin
		nrst = 1'b0;
		mode = pmi_pkg::PMI_GMII;
		speed = pmi_pkg::PMI_S1000;
		full_duplex = 1'b1;
		rx_sym_valid = 1'b0;
		rx_sym = 8'h00;
		rx_sym_err = 1'b0;
		rx_carrier = 1'b0;
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		t_clocks();
		t_gmii();
		t_mii();
		t_rgmii();
		t_rx();
		t_colcrs();
		close_out();
	end
endmodule
